/* rtl/eq_cfg_pkg.sv */
package eq_cfg_pkg;

   localparam int LANES = 4;
   localparam int BOOST_W = 5;
   localparam int BOOST_LEVELS = 32;
   localparam int PIN_LEVELS = 18;
   localparam int CHAIN_LEN = 21;

   // Register byte offsets on the Wishbone slave.
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] BOOST_OFS = 8'h08;
   localparam logic [7:0] STATE_OFS = 8'h0C;

   // Event field layout, shared by status and mask.
   localparam int EVT_W = 5;
   localparam int EVT_LOAD_BIT = 0;
   localparam int EVT_LOSS_LSB = 1;
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [4:0] MASK_RST = 5'h00;

   // State register field positions.
   localparam int STATE_SELECT_N_BIT = 0;
   localparam int STATE_MODE_BIT = 1;
   localparam int STATE_PENDING_BIT = 2;

   // Digit A is two-valued; digits B and C are three-valued (low, mid, high).
   typedef struct packed {
      logic a;
      logic [1:0] b;
      logic [1:0] c;
   } boost_pins_t;

   typedef struct packed {
      logic clk;
      logic din;
      logic select_n;
      logic mode;
   } serial_pins_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   // Spreads the 18 pin codes evenly over the 32 levels, so both ends of the range stay reachable.
   function automatic logic [4:0] pin_level(input boost_pins_t p);
      logic [9:0] code;
      logic [9:0] lvl;
      code = 10'(p.a) * 10'd9;
      code = code + ((p.b > 2'd2) ? 10'd2 : 10'(p.b)) * 10'd3;
      code = code + ((p.c > 2'd2) ? 10'd2 : 10'(p.c));
      lvl = (code * 10'(BOOST_LEVELS - 1) + 10'((PIN_LEVELS - 1) / 2)) / 10'(PIN_LEVELS - 1);
      return lvl[4:0];
   endfunction : pin_level

endpackage : eq_cfg_pkg

/* rtl/quad_equalizer_boost_config.sv */
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Each of the four lanes holds its own boost setting chosen among 32 levels.
// - From the select pins only 18 of the 32 levels can be reached on a lane.
// - Over the serial chain any of the 32 levels can be set on a lane.
// - A lane's three select digits form one code with digit A most and digit C least significant.
// - Serial bits are taken with the serial clock into a chain that holds all four lane settings.
// - Serially loaded settings win over the select pins.
// - The serial output repeats the serial input 21 serial clocks later, as the end of the chain.
// - With mode high the chain can be shifted through the serial input, select and clock pins.
// - With mode low the chain and held settings are zero and the select pins set the boost.
// - A lane's no-signal output is high while its detector reports input below threshold.
// - A lane's output is muted while its detector reports input below threshold, unless the threshold input is grounded.
// - With the threshold input grounded muting is off and every output stays enabled.
// - Shifting happens only at serial clock rises that find the active-low serial select low.
// - The serial input is sampled on each rising serial clock edge that finds the serial select low with mode high.
module quad_equalizer_boost_config #(
   parameter int LANES = eq_cfg_pkg::LANES,
   parameter int CHAIN_LEN = eq_cfg_pkg::CHAIN_LEN
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire eq_cfg_pkg::serial_pins_t i_serial,
   input wire eq_cfg_pkg::boost_pins_t [LANES-1:0] i_lane_boost_select,
   input wire logic [LANES-1:0] i_lane_below_threshold,
   input wire logic i_detect_threshold_grounded,
   input wire eq_cfg_pkg::wb_req_t i_wb,
   output logic o_serial_out,
   output logic [LANES-1:0][eq_cfg_pkg::BOOST_W-1:0] o_lane_boost,
   output logic [LANES-1:0] o_lane_no_signal,
   output logic [LANES-1:0] o_lane_mute,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_irq
);

   localparam int BW = eq_cfg_pkg::BOOST_W;
   localparam int EW = eq_cfg_pkg::EVT_W;

   // Two-stage synchronisers for every pin from outside the reference clock.
   eq_cfg_pkg::serial_pins_t ser_s1;
   eq_cfg_pkg::serial_pins_t ser_s2;
   eq_cfg_pkg::boost_pins_t [LANES-1:0] sel_s1;
   eq_cfg_pkg::boost_pins_t [LANES-1:0] sel_s2;
   logic [LANES-1:0] below_s1;
   logic [LANES-1:0] below_s2;
   logic thr_s1;
   logic thr_s2;

   logic clk_d;
   logic select_n_d;
   logic [CHAIN_LEN-1:0] chain;
   logic pending;
   logic [LANES-1:0][BW-1:0] held;
   logic [LANES-1:0][BW-1:0] next_boost;
   logic [EW-1:0] status;
   logic [EW-1:0] mask;
   logic [EW-1:0] next_status;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ser_s1 <= '0;
         ser_s2 <= '0;
         sel_s1 <= '0;
         sel_s2 <= '0;
         below_s1 <= '0;
         below_s2 <= '0;
         thr_s1 <= 1'b0;
         thr_s2 <= 1'b0;
      end else begin
         ser_s1 <= i_serial;
         ser_s2 <= ser_s1;
         sel_s1 <= i_lane_boost_select;
         sel_s2 <= sel_s1;
         below_s1 <= i_lane_below_threshold;
         below_s2 <= below_s1;
         thr_s1 <= i_detect_threshold_grounded;
         thr_s2 <= thr_s1;
      end
   end

   // Edge finding on the synchronised serial clock and select.
   wire serial_rise = ser_s2.clk & ~clk_d;
   wire serial_mode = ser_s2.mode;
   wire shift_en = serial_rise & ~ser_s2.select_n & serial_mode;
   wire select_close = ser_s2.select_n & ~select_n_d;
   wire load_en = select_close & serial_mode & pending;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_d <= 1'b0;
         select_n_d <= 1'b1;
      end else begin
         clk_d <= ser_s2.clk;
         select_n_d <= ser_s2.select_n;
      end
   end

   // The chain is one stage longer than the lane settings, which gives the 21-clock echo.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         chain <= '0;
      end else if (!serial_mode) begin
         chain <= '0;
      end else if (shift_en) begin
         chain <= {chain[CHAIN_LEN-2:0], ser_s2.din};
      end
   end

   assign o_serial_out = chain[CHAIN_LEN-1];

   // Pending marks shifted data not yet moved to the held settings.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pending <= 1'b0;
      end else if (!serial_mode) begin
         pending <= 1'b0;
      end else if (shift_en) begin
         pending <= 1'b1;
      end else if (load_en) begin
         pending <= 1'b0;
      end
   end

   // Held settings only take chain data when the select closes, so half-shifted data never reaches a lane.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         held <= '0;
      end else if (!serial_mode) begin
         held <= '0;
      end else if (load_en) begin
         held <= chain[LANES*BW-1:0];
      end
   end

   genvar k;
   generate
      for (k = 0; k < LANES; k++) begin : g_lane
         assign next_boost[k] = serial_mode ? held[k] : eq_cfg_pkg::pin_level(sel_s2[k]);

         chk_pin_level: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
            !serial_mode |=> o_lane_boost[k] == eq_cfg_pkg::pin_level($past(sel_s2[k])))
            else $error("lane boost does not follow its select pins");
         chk_serial_wins: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
            serial_mode |=> o_lane_boost[k] == $past(held[k]))
            else $error("lane boost does not follow the serial setting");
      end
   endgenerate

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lane_boost <= '0;
         o_lane_no_signal <= '0;
         o_lane_mute <= '0;
      end else begin
         o_lane_boost <= next_boost;
         o_lane_no_signal <= below_s2;
         o_lane_mute <= below_s2 & {LANES{~thr_s2}};
      end
   end

   // Wishbone classic slave: one wait state, ack for one cycle, unmapped reads return zero.
   wire wb_req = i_wb.cyc & i_wb.stb & ~o_wb_ack;
   wire wb_wr = wb_req & i_wb.we;
   wire wb_rd = wb_req & ~i_wb.we;
   wire hit_status = i_wb.adr == eq_cfg_pkg::STATUS_OFS;
   wire hit_mask = i_wb.adr == eq_cfg_pkg::MASK_OFS;
   wire hit_boost = i_wb.adr == eq_cfg_pkg::BOOST_OFS;
   wire hit_state = i_wb.adr == eq_cfg_pkg::STATE_OFS;
   wire status_clear = wb_rd & hit_status;
   wire mask_write = wb_wr & hit_mask & i_wb.sel[0];
   wire [LANES-1:0] loss_rise = below_s2 & ~o_lane_no_signal;
   wire [EW-1:0] evt_set = EW'({loss_rise, load_en});
   wire [31:0] state_word = 32'({pending, serial_mode, ser_s2.select_n});
   wire [31:0] rd_word = hit_status ? 32'(status) :
                         hit_mask ? 32'(mask) :
                         hit_boost ? 32'(o_lane_boost) :
                         hit_state ? state_word : 32'h0000_0000;

   // A read clears the status it returns; an event in the same cycle still sets its bit.
   assign next_status = (status & ~{EW{status_clear}}) | evt_set;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= wb_rd ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         status <= eq_cfg_pkg::STATUS_RST;
         mask <= eq_cfg_pkg::MASK_RST;
      end else begin
         status <= next_status;
         if (mask_write) begin
            mask <= i_wb.dat[EW-1:0];
         end
      end
   end

   assign o_irq = |(status & mask);

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence seq_wb_take;
      i_wb.cyc && i_wb.stb && !o_wb_ack;
   endsequence

   sequence seq_ack_once;
      o_wb_ack ##1 !o_wb_ack;
   endsequence

   sequence seq_select_close;
      serial_mode && pending && ser_s2.select_n && !select_n_d;
   endsequence

   chk_wb_ack_pulse: assert property (seq_wb_take |=> seq_ack_once)
      else $error("bus ack is not a single cycle after the request");

   chk_shift_sample: assert property (shift_en |=> chain[0] == $past(ser_s2.din))
      else $error("serial bit not captured on the clock rise");

   chk_chain_echo: assert property (shift_en |=> o_serial_out == $past(chain[CHAIN_LEN-2]))
      else $error("serial output is not the far end of the chain");

   chk_no_shift_idle: assert property (ser_s2.select_n |=> $stable(chain) || !$past(serial_mode))
      else $error("chain moved while the serial select was high");

   chk_mode_clear: assert property (!serial_mode |=> chain == '0 && held == '0 && !pending)
      else $error("mode low did not clear the serial settings");

   chk_held_steady: assert property (!select_close && serial_mode |=> $stable(held))
      else $error("held settings changed while the select was open");

   chk_load_close: assert property (seq_select_close |=> held == $past(chain[LANES*BW-1:0]) ##1 !pending)
      else $error("closing the select did not load the shifted settings");

   chk_loss_follow: assert property (##2 (below_s2 == $past(below_s2) && below_s2 == $past(below_s2, 2))
      |-> o_lane_no_signal == below_s2)
      else $error("no-signal output does not follow the detector");

   chk_mute_gate: assert property (thr_s2 |=> o_lane_mute == '0)
      else $error("an output is muted with the threshold grounded");

   chk_mute_loss: assert property (!thr_s2 |=> o_lane_mute == $past(below_s2))
      else $error("mute does not follow the detector");

   chk_status_set: assert property (load_en |=> status[eq_cfg_pkg::EVT_LOAD_BIT])
      else $error("load event lost in the status register");

endmodule : quad_equalizer_boost_config

`default_nettype wire

/* tb/eq_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

module eq_ctrl_model (
   input wire logic i_ref_clk,
   output var eq_cfg_pkg::serial_pins_t o_serial
);
   // Idle: clock low, select high, mode grounded until serial programming is wanted.
   initial o_serial = 4'h2;

   // Twelve reference cycles per bit give 120 ns, about an 8.33 MHz serial clock.
   task automatic half();
      repeat (4) @(posedge i_ref_clk);
   endtask : half

   task automatic set_mode(input logic m);
      o_serial.mode <= m;
      repeat (6) @(posedge i_ref_clk);
   endtask : set_mode

   // Select stays at sel_n for the whole frame; the data line is inverted once its hold has run out.
   task automatic frame(input logic [63:0] bits, input int n, input logic sel_n);
      o_serial.select_n <= sel_n;
      for (int i = n - 1; i >= 0; i--) begin
         half();
         o_serial.din <= bits[i];
         half();
         o_serial.clk <= 1'b1;
         half();
         o_serial.clk <= 1'b0;
         o_serial.din <= ~bits[i];
      end
      half();
   endtask : frame

   task automatic release_sel();
      o_serial.select_n <= 1'b1;
      repeat (8) @(posedge i_ref_clk);
   endtask : release_sel
endmodule : eq_ctrl_model

`default_nettype wire

/* tb/tb_quad_equalizer_boost_config.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_quad_equalizer_boost_config;
   logic i_ref_clk, i_nrst, gnd_thr, so, ack, irq;
   eq_cfg_pkg::serial_pins_t ser;
   eq_cfg_pkg::boost_pins_t [3:0] pins;
   eq_cfg_pkg::wb_req_t wb;
   logic [3:0] below, nosig, mute;
   logic [3:0][4:0] boost;
   logic [31:0] rdat, rd;
   logic [4:0] exp_b [4];
   int fail_count, cmp_count, c;

   eq_ctrl_model ctl (.i_ref_clk(i_ref_clk), .o_serial(ser));

   quad_equalizer_boost_config DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_serial(ser),
      .i_lane_boost_select(pins), .i_lane_below_threshold(below), .i_detect_threshold_grounded(gnd_thr),
      .i_wb(wb), .o_serial_out(so), .o_lane_boost(boost), .o_lane_no_signal(nosig), .o_lane_mute(mute),
      .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));

   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   // One classic cycle; the request stands until ack is sampled high, then one idle cycle.
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int t;
      t = 0;
      wb <= {1'b1, 1'b1, we, adr, 4'hF, wd};
      do begin
         @(posedge i_ref_clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      rd = rdat;
      if (t >= 50) fail_count++;
      wb <= '0;
      @(posedge i_ref_clk);
   endtask : bus

   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   initial begin
      #500000;
      fail_count++;
      conclude();
   end

   initial begin
      i_nrst = 1'b0;
      pins = '0;
      below = '0;
      gnd_thr = 1'b0;
      wb = '0;
      fail_count = 0;
      cmp_count = 0;
      repeat (20) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      // Every pin code on some lane, then digits B and C at the out-of-range value 3.
      for (int n = 0; n < 19; n++) begin
         for (int l = 0; l < 4; l++) begin
            c = (n == 18) ? 17 : (n + 5 * l) % 18;
            pins[l] <= (n == 18) ? 5'h1F : {1'(c / 9), 2'(c / 3 % 3), 2'(c % 3)};
            exp_b[l] = 5'((c * 31 + 8) / 17);
         end
         repeat (4) @(posedge i_ref_clk);
         for (int l = 0; l < 4; l++) check("pin boost", 32'(exp_b[l]), 32'(boost[l]));
      end
      bus(1'b1, 8'h04, 32'h0000001F);
      bus(1'b0, 8'h04, '0); check("mask", 32'h0000001F, rd);
      bus(1'b0, 8'h10, '0); check("unmapped", 32'h00000000, rd);
      bus(1'b0, 8'h0C, '0); check("state", 32'h00000001, rd);
      pins <= {4{5'h10}};
      ctl.set_mode(1'b1);
      check("serial wins", 32'h0, 32'(boost));
      ctl.frame(64'h28A3F, 20, 1'b0);
      check("held during shift", 32'h0, 32'(boost));
      ctl.release_sel();
      check("loaded boost", 32'h28A3F, 32'(boost));
      check("irq on load", 32'h1, 32'(irq));
      bus(1'b0, 8'h08, '0); check("boost reg", 32'h28A3F, rd);
      bus(1'b0, 8'h00, '0); check("status", 32'h00000001, rd);
      check("irq cleared", 32'h0, 32'(irq));
      ctl.frame(64'h100000, 21, 1'b0);
      ctl.release_sel();
      check("chain out one", 32'h1, 32'(so));
      ctl.frame(64'h0FFFFF, 21, 1'b0);
      ctl.release_sel();
      check("chain out zero", 32'h0, 32'(so));
      check("full level", 32'hFFFFF, 32'(boost));
      ctl.frame(64'h0, 20, 1'b1);
      ctl.release_sel();
      check("ignored clocks", 32'h0, 32'(so));
      check("ignored boost", 32'hFFFFF, 32'(boost));
      ctl.set_mode(1'b0);
      check("pins after mode low", 32'h84210, 32'(boost));
      ctl.set_mode(1'b1);
      check("cleared held", 32'h0, 32'(boost));
      below <= 4'h5;
      repeat (5) @(posedge i_ref_clk);
      check("no signal", 32'h5, 32'(nosig));
      check("mute", 32'h5, 32'(mute));
      bus(1'b0, 8'h00, '0); check("loss status", 32'h0000000B, rd);
      gnd_thr <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      check("mute off", 32'h0, 32'(mute));
      check("no signal kept", 32'h5, 32'(nosig));
      conclude();
   end
endmodule : tb_quad_equalizer_boost_config

`default_nettype wire
